// *** rtl/jtp_tap.sv ***
// Test access port controller with instruction and data registers
module jtp_tap (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Test pins
  input wire jtp_pkg::jtp_pins_type pins_i,
  output jtp_pkg::jtp_out_type port_o,
  // I/O ring
  input wire logic [jtp_pkg::JTP_BSR_W-1:0] ring_i,
  output logic [jtp_pkg::JTP_BSR_W-1:0] ring_o,
  output logic ring_take_o,
  output logic float_q_o,
  output logic odt_off_o
);
  import jtp_pkg::*;

  jtp_pins_type sp;
  logic tck_prev_q;
  logic rise;
  logic fall;
  jtp_state_type state_q;
  jtp_state_type state_d;
  logic [JTP_IR_W-1:0] ir_shift_q;
  logic [JTP_IR_W-1:0] ir_q;
  logic [JTP_ID_W-1:0] id_q;
  logic [JTP_BSR_W-1:0] bsr_q;
  logic [JTP_BSR_W-1:0] bsr_upd_q;
  logic byp_q;
  logic serial_out;
  logic [2:0] tms_cnt_q;

  jtp_sync u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pins_i(pins_i),
    .pins_o(sp)
  );

  function automatic logic uses_bsr(input logic [JTP_IR_W-1:0] ir);
    uses_bsr = (ir == JTP_IR_EXTEST) || (ir == JTP_IR_SAMPLE_Z) ||
               (ir == JTP_IR_SAMPLE);
  endfunction : uses_bsr

  always_ff @(posedge clk_i) begin
    if (!rstn_i) tck_prev_q <= 1'b0;
    else tck_prev_q <= sp.tck;
  end
  assign rise = sp.tck & ~tck_prev_q;
  assign fall = ~sp.tck & tck_prev_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      JTP_RESET: state_d = sp.tms ? JTP_RESET : JTP_IDLE;
      JTP_IDLE: state_d = sp.tms ? JTP_SEL_DR : JTP_IDLE;
      JTP_SEL_DR: state_d = sp.tms ? JTP_SEL_IR : JTP_CAP_DR;
      JTP_CAP_DR: state_d = sp.tms ? JTP_EX1_DR : JTP_SHIFT_DR;
      JTP_SHIFT_DR: state_d = sp.tms ? JTP_EX1_DR : JTP_SHIFT_DR;
      JTP_EX1_DR: state_d = sp.tms ? JTP_UPD_DR : JTP_PAUSE_DR;
      JTP_PAUSE_DR: state_d = sp.tms ? JTP_EX2_DR : JTP_PAUSE_DR;
      JTP_EX2_DR: state_d = sp.tms ? JTP_UPD_DR : JTP_SHIFT_DR;
      JTP_UPD_DR: state_d = sp.tms ? JTP_SEL_DR : JTP_IDLE;
      JTP_SEL_IR: state_d = sp.tms ? JTP_RESET : JTP_CAP_IR;
      JTP_CAP_IR: state_d = sp.tms ? JTP_EX1_IR : JTP_SHIFT_IR;
      JTP_SHIFT_IR: state_d = sp.tms ? JTP_EX1_IR : JTP_SHIFT_IR;
      JTP_EX1_IR: state_d = sp.tms ? JTP_UPD_IR : JTP_PAUSE_IR;
      JTP_PAUSE_IR: state_d = sp.tms ? JTP_EX2_IR : JTP_PAUSE_IR;
      JTP_EX2_IR: state_d = sp.tms ? JTP_UPD_IR : JTP_SHIFT_IR;
      JTP_UPD_IR: state_d = sp.tms ? JTP_SEL_DR : JTP_IDLE;
      default: state_d = JTP_RESET;
    endcase
  end

  // Mode select taken only at test clock rising edges
  always_ff @(posedge clk_i) begin
    if (!rstn_i) state_q <= JTP_RESET;
    else if (rise) state_q <= state_d;
  end

  // Count of consecutive high mode-select edges, for checking only
  always_ff @(posedge clk_i) begin
    if (!rstn_i) tms_cnt_q <= 3'h0;
    else if (rise) begin
      if (!sp.tms) tms_cnt_q <= 3'h0;
      else if (tms_cnt_q != 3'h7) tms_cnt_q <= tms_cnt_q + 3'h1;
    end
  end

  // Instruction shifter
  always_ff @(posedge clk_i) begin
    if (!rstn_i) ir_shift_q <= JTP_IR_RESET;
    else if (rise) begin
      if (state_q == JTP_CAP_IR) ir_shift_q <= JTP_IR_CAPTURE;
      else if (state_q == JTP_SHIFT_IR)
        ir_shift_q <= {sp.tdi, ir_shift_q[JTP_IR_W-1:1]};
    end
  end

  // Active instruction changes only at update or in reset, so shifting is harmless
  // Reset state forces ident at once, even if the test clock then stops
  always_ff @(posedge clk_i) begin
    if (!rstn_i) ir_q <= JTP_IR_RESET;
    else if (state_q == JTP_RESET) ir_q <= JTP_IR_RESET;
    else if (rise && state_q == JTP_UPD_IR) ir_q <= ir_shift_q;
  end

  // Data registers: identification, boundary scan, bypass
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      id_q <= JTP_ID_VALUE;
      bsr_q <= '0;
      byp_q <= 1'b0;
    end else if (rise) begin
      if (state_q == JTP_CAP_DR) begin
        id_q <= JTP_ID_VALUE;
        if (uses_bsr(ir_q)) bsr_q <= ring_i;
        byp_q <= 1'b0;
      end else if (state_q == JTP_SHIFT_DR) begin
        if (ir_q == JTP_IR_IDCODE) id_q <= {sp.tdi, id_q[JTP_ID_W-1:1]};
        else if (uses_bsr(ir_q)) bsr_q <= {sp.tdi, bsr_q[JTP_BSR_W-1:1]};
        else byp_q <= sp.tdi;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) bsr_upd_q <= '0;
    else if (rise && state_q == JTP_UPD_DR && ir_q == JTP_IR_EXTEST)
      bsr_upd_q <= bsr_q;
  end

  always_comb begin
    if (state_q == JTP_SHIFT_IR) serial_out = ir_shift_q[0];
    else if (ir_q == JTP_IR_IDCODE) serial_out = id_q[0];
    else if (uses_bsr(ir_q)) serial_out = bsr_q[0];
    else serial_out = byp_q;
  end

  // Output moves at the next test clock falling edge after the shift, giving hold margin
  always_ff @(posedge clk_i) begin
    if (!rstn_i) port_o <= '{tdo: 1'b0, tdo_oe: 1'b0};
    else if (fall) begin
      port_o.tdo <= serial_out;
      port_o.tdo_oe <= (state_q == JTP_SHIFT_IR) ||
                       (state_q == JTP_SHIFT_DR);
    end
  end

  // Ring takeover only under external test; outputs float only under floated sample
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ring_take_o <= 1'b0;
      float_q_o <= 1'b0;
      odt_off_o <= 1'b0;
      ring_o <= '0;
    end else begin
      ring_take_o <= (ir_q == JTP_IR_EXTEST);
      float_q_o <= (ir_q == JTP_IR_SAMPLE_Z);
      odt_off_o <= (ir_q == JTP_IR_EXTEST) || (ir_q == JTP_IR_SAMPLE_Z);
      ring_o <= bsr_upd_q;
    end
  end

  a_five_ones_reset: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (rise && tms_cnt_q >= 3'h4 && sp.tms) |=> state_q == JTP_RESET)
    else $error("Five high mode-select edges did not reset");
  a_state_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !rise |=> $stable(state_q))
    else $error("State changed without test clock edge");
  a_oe_shift_only: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (fall && state_q != JTP_SHIFT_IR && state_q != JTP_SHIFT_DR)
    |=> !port_o.tdo_oe)
    else $error("Output enabled outside shift");
  a_tdo_on_fall: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !fall |=> $stable(port_o.tdo))
    else $error("Data out moved off falling edge");
  a_ir_reset_id: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (rise && state_q == JTP_RESET) |=> ir_q == JTP_IR_IDCODE)
    else $error("Reset state did not load ident");
  a_ir_upd_only: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state_q != JTP_UPD_IR && state_q != JTP_RESET) |=> $stable(ir_q))
    else $error("Instruction changed outside update");
  a_ir_shift_in: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (rise && state_q == JTP_SHIFT_IR) |=> ir_shift_q[2] == $past(sp.tdi))
    else $error("Instruction shifter missed data in");
  a_takeover_mode: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 (ring_take_o || float_q_o) |-> ($past(ir_q) == JTP_IR_EXTEST ||
    $past(ir_q) == JTP_IR_SAMPLE_Z))
    else $error("Ring taken under wrong instruction");
  a_graph_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (rise && state_q == JTP_SEL_IR && sp.tms) |=> state_q == JTP_RESET)
    else $error("Select-IR with mode high did not reset");
  a_cap_ir_load: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (rise && state_q == JTP_CAP_IR) |=> ir_shift_q == JTP_IR_CAPTURE)
    else $error("Instruction capture did not load ident");
  a_reset_ident: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_q == JTP_RESET |=> ir_q == JTP_IR_IDCODE)
    else $error("Reset state left a non-ident instruction");
  a_id_capture: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (rise && state_q == JTP_CAP_DR) |=> id_q == JTP_ID_VALUE)
    else $error("Ident register not captured");
  a_byp_capture: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (rise && state_q == JTP_CAP_DR) |=> !byp_q)
    else $error("Bypass bit not cleared at capture");
  a_float_mode: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ir_q == JTP_IR_SAMPLE_Z |=> float_q_o)
    else $error("Floated sample did not float outputs");
endmodule : jtp_tap

// *** rtl/jtp_pkg.sv ***
// Package for the test access port block
package jtp_pkg;
  localparam int JTP_IR_W = 3;
  localparam int JTP_ID_W = 32;
  localparam int JTP_BSR_W = 16;
  localparam logic [2:0] JTP_IR_EXTEST = 3'h0;
  localparam logic [2:0] JTP_IR_IDCODE = 3'h1;
  localparam logic [2:0] JTP_IR_SAMPLE_Z = 3'h2;
  localparam logic [2:0] JTP_IR_RESERVED_MAKER_INSTRUCTION = 3'h3;
  localparam logic [2:0] JTP_IR_SAMPLE = 3'h4;
  localparam logic [2:0] JTP_IR_RESET = JTP_IR_IDCODE;
  // Captured into the instruction register low bits, per convention
  localparam logic [2:0] JTP_IR_CAPTURE = JTP_IR_IDCODE;
  // Arbitrary identification value, not tied to any maker
  localparam logic [31:0] JTP_ID_VALUE = 32'h1234_5679;
  localparam int JTP_RESET_TMS_EDGES = 5;

  typedef enum logic [3:0] {
    JTP_RESET, JTP_IDLE, JTP_SEL_DR, JTP_CAP_DR, JTP_SHIFT_DR, JTP_EX1_DR,
    JTP_PAUSE_DR, JTP_EX2_DR, JTP_UPD_DR, JTP_SEL_IR, JTP_CAP_IR,
    JTP_SHIFT_IR, JTP_EX1_IR, JTP_PAUSE_IR, JTP_EX2_IR, JTP_UPD_IR
  } jtp_state_type;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtp_pins_type;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } jtp_out_type;
endpackage : jtp_pkg

// *** rtl/jtp_sync.sv ***
// Two-stage synchroniser for the test pins
module jtp_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Pins
  input wire jtp_pkg::jtp_pins_type pins_i,
  output jtp_pkg::jtp_pins_type pins_o
);
  import jtp_pkg::*;
  jtp_pins_type meta_q;
  jtp_pins_type sync_q;

  // Reset value mirrors an idle port: clock low, pulled-up inputs high
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_q <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
      sync_q <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
    end else begin
      meta_q <= pins_i;
      sync_q <= meta_q;
    end
  end

  assign pins_o = sync_q;
endmodule : jtp_sync

// *** dv/jtp_ctrl_model.sv ***
// Behavioural test controller driving the test pins
module jtp_ctrl_model (
  // Clock
  input wire logic clk_i,
  // Test pins
  output jtp_pkg::jtp_pins_type pins_o,
  input wire jtp_pkg::jtp_out_type port_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import jtp_pkg::*;
  logic last_q = 1'b0;
  // Released data-out shows the inverse, never a held bit
  always @(posedge clk_i) begin
    if (port_i.tdo_oe) last_q <= port_i.tdo;
  end
  initial pins_o = 3'b011;
  // One 200 ns period; long low half lets data-out settle
  task automatic step(input logic m, input logic d, output jtp_out_type o);
    pins_o.tms = m;
    pins_o.tdi = d;
    repeat (5) @(posedge clk_i);
    #1;
    o = port_i;
    if (!o.tdo_oe) o.tdo = ~last_q;
    pins_o.tck = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    pins_o.tck = 1'b0;
  endtask : step
  // Mode select wiggles while the test clock stays low
  task automatic idle_low(input int n);
    repeat (n) begin
      @(posedge clk_i);
      #1;
      pins_o.tms = ~pins_o.tms;
    end
    // Let an edge pass so the next step never re-drives in this time step
    @(posedge clk_i);
    #1;
  endtask : idle_low
endmodule : jtp_ctrl_model

// *** dv/testbench.sv ***
// Self-checking bench for the test access port block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import jtp_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [15:0] ring_i = 16'hC3A5;
  logic [15:0] ring_o;
  logic ring_take_o, float_q_o, odt_off_o;
  jtp_pins_type pins;
  jtp_out_type port, s;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  jtp_ctrl_model jtp_ctrl_model_inst (.clk_i(clk_i), .pins_o(pins),
    .port_i(port));
  jtp_tap jtp_tap_inst (.clk_i(clk_i), .rstn_i(rstn_i), .pins_i(pins),
    .port_o(port), .ring_i(ring_i), .ring_o(ring_o),
    .ring_take_o(ring_take_o), .float_q_o(float_q_o),
    .odt_off_o(odt_off_o));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic st(input logic m, input logic d);
    jtp_ctrl_model_inst.step(m, d, s);
  endtask : st
  // From idle: shift n bits LSB first, update, back to idle
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
      output logic [31:0] dout);
    dout = '0;
    st(1'b1, 1'b1);
    if (ir) st(1'b1, 1'b1);
    st(1'b0, 1'b1);
    st(1'b0, 1'b1);
    for (int i = 0; i < n; i++) begin
      jtp_ctrl_model_inst.step(i == n - 1, din[i], s);
      dout[i] = s.tdo;
      check(s.tdo_oe, 1'b1);
    end
    st(1'b1, 1'b1);
    st(1'b0, 1'b1);
    check(port.tdo_oe, 1'b0);
  endtask : scan
  task automatic t_reset();
    check({ring_take_o, float_q_o, odt_off_o, port.tdo_oe}, 32'h0);
    repeat (5) st(1'b1, 1'b1);
    st(1'b0, 1'b1);
  endtask : t_reset
  task automatic t_idcode();
    logic [31:0] d;
    scan(1'b0, 32'h0, 32, d);
    check(d, JTP_ID_VALUE);
  endtask : t_idcode
  task automatic t_modes();
    logic [31:0] d;
    logic [2:0] c;
    for (int k = 4; k >= 0; k--) begin
      c = 3'(k);
      scan(1'b1, {29'h0, c}, 3, d);
      // Mode outputs are registered one clock after the instruction
      repeat (2) @(posedge clk_i);
      #1;
      check(d, 32'h1);
      check(ring_take_o, c == 3'h0);
      check(float_q_o, c == 3'h2);
      check(odt_off_o, c == 3'h0 || c == 3'h2);
      if (c == 3'h3) begin
        scan(1'b0, 32'hA5, 8, d);
        check(d, 32'h4A);
      end else if (c != 3'h1) begin
        scan(1'b0, 32'h5A3C, 16, d);
        check(d, ring_i);
      end
    end
    repeat (2) @(posedge clk_i);
    #1;
    check(ring_o, 32'h5A3C);
  endtask : t_modes
  // Four high edges from shift must not yet reset; the fifth must
  task automatic t_tmsreset();
    jtp_ctrl_model_inst.idle_low(12);
    check(ring_take_o, 1'b1);
    st(1'b1, 1'b1);
    st(1'b0, 1'b1);
    st(1'b0, 1'b1);
    repeat (4) st(1'b1, 1'b1);
    check(ring_take_o, 1'b1);
    st(1'b1, 1'b1);
    // Fifth edge alone must drop the takeover, with the test clock stopped
    repeat (3) @(posedge clk_i);
    #1;
    check({ring_take_o, odt_off_o}, 32'h0);
  endtask : t_tmsreset
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    t_reset();
    t_idcode();
    t_modes();
    t_tmsreset();
    report_and_stop();
  end
endmodule : testbench
